// >>> logic/mcu_exec_core.sv
// executes a subset of the 14-bit instruction set: clear working register,
// complement and decrement of a file register, clear watchdog and the three
// stack returns, plus interrupt entry. registers reached over apb.
// assumes a synchronous program memory: instr_data shows the word at the
// fetch_addr of the previous edge; irq_pin comes from outside the clock domain.
`include "mcu_exec_params.svh"

module mcu_exec_core
  import mcu_exec_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  output logic [`PC_WIDTH-1:0]      fetch_addr,
  input  wire logic [13:0]          instr_data,
  input  wire logic                 irq_pin,
  output logic                      global_irq_enable,
  output logic                      wdog_timeout,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // instruction class from the fetched word; x bits of the literal return ignored
  function automatic op_t decode_op(input logic [13:0] word);
    op_t cls;
    cls = op_nop;
    if (word == `CLEAR_WORK_CODE) cls = clear_work_reg_op;
    else if (word == `CLEAR_WDOG_CODE) cls = clear_watchdog_op;
    else if (word == `RETURN_IRQ_CODE) cls = return_from_irq_op;
    else if (word == `RETURN_SUB_CODE) cls = return_sub_op;
    else if (word[13:8] == `COMPLEMENT_PREFIX) cls = complement_file_op;
    else if (word[13:8] == `DECREMENT_PREFIX) cls = decrement_file_op;
    else if (word[13:10] == `RET_LITERAL_PREFIX) cls = return_with_literal_op;
    return cls;
  endfunction

  // apb offset match, used for reads and writes alike
  function automatic logic offset_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [`PC_WIDTH-1:0]            fetch_addr_reg;
  logic [`PC_WIDTH-1:0]            fetch_addr_next;
  logic [`PC_WIDTH-1:0]            exec_pc_reg;
  logic                            flush_reg;
  logic [7:0]                      work_reg;
  logic [7:0]                      work_next;
  logic                            zero_flag_reg;
  logic                            zero_flag_next;
  logic                            timeout_flag_n;
  logic                            powerdown_flag_n;
  logic                            irq_enable_reg;
  logic                            irq_enable_next;
  logic [6:0]                      irq_ctl_low_reg;
  logic [7:0]                      file_mem [128];
  logic [`WDOG_PRESCALE_BITS-1:0]  prescale_reg;
  logic [`WDOG_COUNT_BITS-1:0]     watchdog_counter;
  logic                            wdog_timeout_reg;
  logic [1:0]                      ctrl_reg;
  logic                            irq_meta_reg;
  logic                            irq_sync_reg;

  // two-flop synchroniser for the external interrupt request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_pin;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execute

  op_t                  op;
  logic                 running;
  logic                 exec_live;
  logic                 irq_take;
  logic [6:0]           file_addr;
  logic                 dest_file;
  logic [7:0]           file_rd;
  logic [7:0]           alu_result;
  logic                 alu_op;
  logic                 file_wr;
  logic                 is_return;
  logic                 stack_push;
  logic                 stack_pop;
  logic [`PC_WIDTH-1:0] stack_top;
  logic                 wdog_clear;
  logic                 prescale_wrap;
  logic                 count_wrap;

  assign running   = ctrl_reg[`CTRL_RUN_BIT];
  // a flushed slot holds a discarded prefetch and runs as a no-operation
  assign exec_live = running && !flush_reg;
  assign op        = exec_live ? decode_op(instr_data) : op_nop;
  // interrupt preempts the instruction in execute; it reruns after return
  assign irq_take  = exec_live && irq_enable_reg && irq_sync_reg;
  assign file_addr = instr_data[`FILE_ADDR_MSB:0];
  assign dest_file = instr_data[`DEST_BIT];

  // file read: status and interrupt control are mapped, the rest is ram
  assign file_rd = (file_addr == `FILE_STATUS_ADDR) ?
                   {3'h0, timeout_flag_n, powerdown_flag_n, zero_flag_reg, 2'h0} :
                   (file_addr == `FILE_IRQ_CTL_ADDR) ? {irq_enable_reg, irq_ctl_low_reg} :
                   file_mem[file_addr];

  // alu: complement or decrement
  assign alu_result = (op == complement_file_op) ? ~file_rd
                                                 : file_rd - 8'h01;
  assign alu_op     = !irq_take &&
                      (op == complement_file_op || op == decrement_file_op);
  assign file_wr    = alu_op && dest_file;

  assign is_return  = !irq_take && (op == return_from_irq_op ||
                      op == return_with_literal_op || op == return_sub_op);
  assign stack_push = irq_take;
  assign stack_pop  = is_return;
  assign wdog_clear = !irq_take && op == clear_watchdog_op;

  // next working register, zero flag and interrupt enable
  always_comb begin
    work_next      = work_reg;
    zero_flag_next = zero_flag_reg;
    irq_enable_next = irq_enable_reg;
    if (irq_take) begin
      irq_enable_next = 1'b0;
    end else begin
      unique case (op)
        clear_work_reg_op: begin
          work_next      = 8'h00;
          zero_flag_next = 1'b1;
        end
        complement_file_op, decrement_file_op: begin
          if (!dest_file) begin
            work_next = alu_result;
          end
          zero_flag_next = (alu_result == 8'h00);
        end
        return_from_irq_op: begin
          irq_enable_next = 1'b1;
        end
        return_with_literal_op: begin
          work_next = instr_data[7:0];
        end
        clear_watchdog_op, return_sub_op, op_nop: begin
          work_next = work_reg;
        end
      endcase
      // a file write into interrupt control moves the enable bit as well
      if (file_wr && file_addr == `FILE_IRQ_CTL_ADDR) begin
        irq_enable_next = alu_result[`IRQ_CTL_ENABLE_BIT];
      end
    end
  end

  // fetch address: jumps load a target and force a flushed slot
  assign fetch_addr_next = !running  ? exec_pc_reg :
                           irq_take  ? `IRQ_VECTOR :
                           is_return ? stack_top :
                           fetch_addr_reg + 13'h0001;

  // pipeline: halting parks fetch on the unexecuted word and refetches it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_addr_reg <= `RESET_VECTOR;
      exec_pc_reg    <= `RESET_VECTOR;
      flush_reg      <= 1'b1;
    end else begin
      fetch_addr_reg <= fetch_addr_next;
      if (running) begin
        exec_pc_reg <= fetch_addr_reg;
      end
      flush_reg <= !running || irq_take || is_return;
    end
  end

  // architectural registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      work_reg        <= 8'h00;
      zero_flag_reg   <= 1'b0;
      irq_enable_reg  <= 1'b0;
      irq_ctl_low_reg <= 7'h00;
    end else begin
      work_reg      <= work_next;
      zero_flag_reg <= zero_flag_next;
      irq_enable_reg <= irq_enable_next;
      if (file_wr && file_addr == `FILE_IRQ_CTL_ADDR) begin
        irq_ctl_low_reg <= alu_result[6:0];
      end
    end
  end

  // general purpose file ram; status writes only change the zero flag
  always_ff @(posedge clk) begin
    if (file_wr && file_addr != `FILE_STATUS_ADDR &&
        file_addr != `FILE_IRQ_CTL_ADDR) begin
      file_mem[file_addr] <= alu_result;
    end
  end

  return_stack u_stack (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (exec_pc_reg),
    .stack_top (stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // watchdog

  // prescaler ticks every clock while enabled; counter advances on its wrap
  assign prescale_wrap = ctrl_reg[`CTRL_WDOG_EN_BIT] && (&prescale_reg);
  assign count_wrap    = prescale_wrap && (&watchdog_counter);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale_reg     <= '0;
      watchdog_counter <= '0;
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
      wdog_timeout_reg <= 1'b0;
    end else if (wdog_clear) begin
      prescale_reg     <= '0;
      watchdog_counter <= '0;
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
      wdog_timeout_reg <= 1'b0;
    end else begin
      if (ctrl_reg[`CTRL_WDOG_EN_BIT]) begin
        prescale_reg <= prescale_reg + 8'h01;
      end
      if (prescale_wrap) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
      // time-out is sticky until cleared by the clear-watchdog instruction
      if (count_wrap) begin
        timeout_flag_n <= 1'b0;
      end
      wdog_timeout_reg <= count_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  logic        acc;
  logic        hit_ctrl;
  logic        hit_work;
  logic        hit_status;
  logic        hit_pc;
  logic        hit_wdog;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  // answer one cycle into the access phase; the ready flop gates repeats
  assign acc        = psel && penable && !pready_reg;
  assign hit_ctrl   = offset_hit(paddr, `REG_CTRL_OFS);
  assign hit_work   = offset_hit(paddr, `REG_WORK_OFS);
  assign hit_status = offset_hit(paddr, `REG_STATUS_OFS);
  assign hit_pc     = offset_hit(paddr, `REG_PC_OFS);
  assign hit_wdog   = offset_hit(paddr, `REG_WDOG_OFS);
  assign mapped     = hit_ctrl || hit_work || hit_status || hit_pc || hit_wdog;
  assign rd_mux     = hit_ctrl   ? {30'h0, ctrl_reg} :
                      hit_work   ? {24'h0, work_reg} :
                      hit_status ? {28'h0, irq_enable_reg, timeout_flag_n,
                                    powerdown_flag_n, zero_flag_reg} :
                      hit_pc     ? {19'h0, exec_pc_reg} :
                      hit_wdog   ? {24'h0, watchdog_counter} : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
      ctrl_reg    <= `CTRL_RESET_VALUE;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc && !mapped;
      prdata_reg  <= (acc && !pwrite) ? rd_mux : 32'h0;
      if (acc && pwrite && hit_ctrl) begin
        ctrl_reg <= pwdata[1:0];
      end
    end
  end

  // outputs straight from flops
  assign fetch_addr        = fetch_addr_reg;
  assign global_irq_enable = irq_enable_reg;
  assign wdog_timeout      = wdog_timeout_reg;
  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;

endmodule

// >>> logic/mcu_exec_params.svh
// constants for the instruction subset executor: codes, field positions,
// register offsets, reset values and watchdog timing.
// assumes a 100 MHz core clock and a synchronous program memory.
//
// Behaviour
// - clear-working-register loads zero into the working register and sets the zero flag in one cycle.
// - complement inverts every bit of the file register picked by the seven-bit field and updates the zero flag.
// - a destination bit of 0 sends the result to the working register, 1 back to the file register.
// - clear-watchdog zeroes the watchdog counter and prescaler and sets the time-out and power-down flags to 1.
// - decrement subtracts one from the file register, places it by the destination bit and touches only the zero flag.
// - return-from-interrupt pops the stack top into the program counter and sets global interrupt enable, no flags change.
// - return-from-interrupt is decoded from its fixed fourteen-bit code and takes two instruction cycles.
// - return-with-literal loads the eight-bit literal into the working register and pops the stack top into the program counter in two cycles, ignoring the two x bits.
// - subroutine return pops the stack top into the program counter in two cycles, leaving working register and flags alone.
// - an accepted interrupt clears global interrupt enable, pushes the return address and jumps to the interrupt vector.
`ifndef MCU_EXEC_PARAMS_SVH
`define MCU_EXEC_PARAMS_SVH

// fixed instruction codes and opcode prefixes
`define CLEAR_WORK_CODE    14'h0103
`define CLEAR_WDOG_CODE    14'h0064
`define RETURN_IRQ_CODE    14'h0009
`define RETURN_SUB_CODE    14'h0008
`define COMPLEMENT_PREFIX  6'h09
`define DECREMENT_PREFIX   6'h03
`define RET_LITERAL_PREFIX 4'hd

// instruction fields
`define DEST_BIT           7
`define FILE_ADDR_MSB      6

// program counter and vectors
`define PC_WIDTH           13
`define RESET_VECTOR       13'h0000
`define IRQ_VECTOR         13'h0004
`define STACK_DEPTH        8
`define STACK_PTR_WIDTH    3

// file register map inside the core
`define FILE_STATUS_ADDR   7'h03
`define FILE_IRQ_CTL_ADDR  7'h0b
`define STATUS_Z_BIT       2
`define STATUS_PD_BIT      3
`define STATUS_TO_BIT      4
`define IRQ_CTL_ENABLE_BIT 7

// apb register offsets (byte addresses)
`define REG_CTRL_OFS       12'h000
`define REG_WORK_OFS       12'h004
`define REG_STATUS_OFS     12'h008
`define REG_PC_OFS         12'h00c
`define REG_WDOG_OFS       12'h010
`define CTRL_RUN_BIT       0
`define CTRL_WDOG_EN_BIT   1
`define CTRL_RESET_VALUE   2'h0

// watchdog: prescaler and counter widths, prescaler tick at clk rate
`define WDOG_PRESCALE_BITS 8
`define WDOG_COUNT_BITS    8

`endif

// >>> logic/mcu_exec_pkg.sv
// types for the instruction subset executor.
// assumes the constants header is compiled alongside.
package mcu_exec_pkg;

  // one-hot decode classes of the fetched instruction
  typedef enum logic [7:0] {
    op_nop                 = 8'h01,
    clear_work_reg_op      = 8'h02,
    complement_file_op     = 8'h04,
    decrement_file_op      = 8'h08,
    clear_watchdog_op      = 8'h10,
    return_from_irq_op     = 8'h20,
    return_with_literal_op = 8'h40,
    return_sub_op          = 8'h80
  } op_t;

endpackage

// >>> logic/return_stack.sv
// hardware return-address stack, eight levels of program counter.
// assumes push and pop are never asserted together; overflow wraps silently.
`include "mcu_exec_params.svh"

module return_stack (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    push,
  input  wire logic                    pop,
  input  wire logic [`PC_WIDTH-1:0]    push_data,
  output logic      [`PC_WIDTH-1:0]    stack_top
);

  logic [`PC_WIDTH-1:0]        slot_reg [`STACK_DEPTH];
  logic [`STACK_PTR_WIDTH-1:0] ptr_reg;
  logic [`STACK_PTR_WIDTH-1:0] ptr_next;
  logic [`STACK_PTR_WIDTH-1:0] top_idx;

  // pointer names the next free slot; the top sits one below it
  assign top_idx   = ptr_reg - 3'h1;
  assign stack_top = slot_reg[top_idx];
  assign ptr_next  = push ? ptr_reg + 3'h1 : (pop ? top_idx : ptr_reg);

  // pointer update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_reg <= 3'h0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // slot storage, no reset needed since the pointer guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      slot_reg[ptr_reg] <= push_data;
    end
  end

endmodule

// >>> dv/prog_rom.sv
// program memory model on the far side of the fetch port: a synchronous rom.
// assumes the bench loads the table through hierarchical writes while idle.
////////////////////////////////////////////////////////////////////////////////
module prog_rom (
  input  wire logic        clk,
  input  wire logic [12:0] addr,
  output logic      [13:0] data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [13:0] mem [0:511];

  // start clean so a halted core never sees unknown words
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 14'h0000;
    end
  end

  // word appears one edge after its address; above the table reads as no-op
  always @(posedge clk) begin
    data <= (addr < 13'h0200) ? mem[addr[8:0]] : 14'h0000;
  end
endmodule

// >>> dv/core_exec_monitor.sv
// port-level checks for the executor: apb handshake, reset state and the
// causes of interrupt enable changes. assumes a bind to the core module.
`include "mcu_exec_params.svh"

module core_exec_monitor (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [`PC_WIDTH-1:0] fetch_addr,
  input wire logic [13:0]          instr_data,
  input wire logic                 irq_pin,
  input wire logic                 global_irq_enable,
  input wire logic                 wdog_timeout,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr
);
  default clocking mon_clk @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // a file write that lands on the interrupt control byte may move the enable
  logic enable_writer;
  assign enable_writer = instr_data[`DEST_BIT]
                      && (instr_data[`FILE_ADDR_MSB:0] == `FILE_IRQ_CTL_ADDR)
                      && ((instr_data[13:8] == `COMPLEMENT_PREFIX)
                          || (instr_data[13:8] == `DECREMENT_PREFIX));

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: answer one cycle after the access edge, single pulse
  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("pready did not answer the access phase");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without a request");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside a response");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero between responses");
  // sync reset: fetch address, interrupt enable, pready and pslverr cleared one edge after reset is seen
  a_reset_state: assert property (disable iff (1'b0)
    !rst_n |=> fetch_addr == `RESET_VECTOR && !global_irq_enable && !pready && !pslverr)
    else $error("outputs not cleared by reset");
  // enable rises only after a return from interrupt or a direct file write
  a_enable_rise: assert property ($rose(global_irq_enable) |->
    $past(instr_data) == `RETURN_IRQ_CODE || $past(enable_writer))
    else $error("interrupt enable set without cause");
  a_enable_fall: assert property ($fell(global_irq_enable) |->
    fetch_addr == `IRQ_VECTOR || $past(enable_writer))
    else $error("interrupt enable cleared without vectoring");
  a_vector_disable: assert property (
    fetch_addr == `IRQ_VECTOR && $past(fetch_addr) != 13'h0003 |-> !global_irq_enable)
    else $error("vector jump left interrupts enabled");
endmodule

bind mcu_exec_core core_exec_monitor core_exec_monitor_inst (
  .clk(clk), .rst_n(rst_n), .fetch_addr(fetch_addr), .instr_data(instr_data),
  .irq_pin(irq_pin), .global_irq_enable(global_irq_enable), .wdog_timeout(wdog_timeout),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> dv/mcu_instruction_subset_exec_tb.sv
// self-checking bench: runs short programs from the rom model, halts the
// core and reads results over apb. assumes core, stack and rom are compiled.
`include "mcu_exec_params.svh"

module mcu_instruction_subset_exec_tb import mcu_exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk = 1'b0, rst_n = 1'b0, irq_pin = 1'b0;
  logic [`PC_WIDTH-1:0] fetch_addr;
  logic [13:0]          instr_data;
  logic                 global_irq_enable, wdog_timeout, pready, pslverr, err;
  logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0, prdata, rd;
  int                   num_errors = 0, checks = 0, cycles = 0, n;
  // file 0x0b forms: inverse/decrement, d=1 back to file, d=0 to working reg
  localparam logic [13:0] nop = 14'h0000, kd = `CLEAR_WDOG_CODE, zw = `CLEAR_WORK_CODE;
  localparam logic [13:0] ift = 14'h098b, ifw = 14'h090b, dfw = 14'h030b, dff = 14'h038b;
  localparam logic [13:0] rlit = 14'h375a;  // don't-care bits set on purpose

  always #5 clk = ~clk;

  mcu_exec_core mcu_exec_core_inst (.clk(clk), .rst_n(rst_n), .fetch_addr(fetch_addr),
    .instr_data(instr_data), .irq_pin(irq_pin), .global_irq_enable(global_irq_enable),
    .wdog_timeout(wdog_timeout), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  prog_rom prog_rom_inst (.clk(clk), .addr(fetch_addr), .data(instr_data));

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: the whole run needs little more than a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      $display("MISMATCH at %0t: run timed out", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_pc(input logic [`PC_WIDTH-1:0] a);
    while (fetch_addr !== a) @(posedge clk);
  endtask

  // short reset and a blank program: every scenario starts from the same state
  task automatic prep();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 512; n++) prog_rom_inst.mem[n] = nop;
  endtask

  // run seven words; with isr the vector code at 4..6 is blanked after use,
  // since straight-line flow would otherwise run its return on an empty stack
  task automatic scen(input logic [13:0] w0, w1, w2, w3, w4, w5, w6, input logic isr,
                      input logic [31:0] ew, input logic [31:0] es);
    prep();
    {prog_rom_inst.mem[6], prog_rom_inst.mem[5], prog_rom_inst.mem[4], prog_rom_inst.mem[3],
     prog_rom_inst.mem[2], prog_rom_inst.mem[1], prog_rom_inst.mem[0]} =
      {w6, w5, w4, w3, w2, w1, w0};
    irq_pin <= isr;
    apb(1'b1, `REG_CTRL_OFS, 32'h1);
    if (isr) begin
      wait_pc(`IRQ_VECTOR);
      irq_pin <= 1'b0;
      n = 0;
      while (fetch_addr >= 13'h0004) begin
        @(posedge clk);
        n++;
      end
      chk(n, 32'd3, "cycles from vector to return");
      chk(fetch_addr >= 13'h0001 && fetch_addr <= 13'h0003, 32'h1, "return address");
      for (n = 4; n < 7; n++) prog_rom_inst.mem[n] = nop;
    end
    repeat (40) @(posedge clk);
    apb(1'b1, `REG_CTRL_OFS, 32'h0);
    apb(1'b0, `REG_WORK_OFS, 32'h0);
    chk(rd, ew, "working register");
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk(rd & 32'hf, es, "status flags");
    chk(global_irq_enable, es[3], "interrupt enable pin");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `REG_CTRL_OFS, 32'h0);
    chk(rd, 32'h0, "control reset value");
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    chk(err, 1'b1, "unmapped error");
    scen(kd, zw, nop, nop, nop, nop, nop, 1'b0, 32'h00, 32'h7);
    apb(1'b1, `REG_WORK_OFS, 32'hff);
    apb(1'b0, `REG_WORK_OFS, 32'h0);
    chk(rd, 32'h0, "read-only working register");
    scen(kd, zw, ift, nop, nop, nop, nop, 1'b0, 32'h00, 32'he);
    scen(kd, ift, dfw, nop, nop, nop, nop, 1'b0, 32'hfe, 32'he);
    scen(kd, ift, ifw, nop, nop, nop, nop, 1'b0, 32'h00, 32'hf);
    scen(kd, ift, dff, ifw, nop, nop, nop, 1'b0, 32'h01, 32'he);
    scen(kd, zw, ift, ift, nop, nop, nop, 1'b0, 32'h00, 32'h7);
    scen(ift, nop, nop, kd, zw, rlit, zw, 1'b1, 32'h5a, 32'h7);
    scen(ift, nop, nop, kd, zw, `RETURN_IRQ_CODE, zw, 1'b1, 32'h00, 32'hf);
    scen(ift, nop, nop, kd, dfw, `RETURN_SUB_CODE, zw, 1'b1, 32'h7e, 32'h6);
    // watchdog: a late clear must zero both counter and prescaler
    prep();
    prog_rom_inst.mem[448] = kd;
    apb(1'b1, `REG_CTRL_OFS, 32'h3);
    wait_pc(13'h0208);
    apb(1'b1, `REG_CTRL_OFS, 32'h0);
    apb(1'b0, `REG_WDOG_OFS, 32'h0);
    chk(rd, 32'h0, "watchdog count after clear");
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk(rd & 32'h6, 32'h6, "timeout and powerdown flags");
    chk(wdog_timeout, 1'b0, "no timeout pulse after clear");
    // halt lands three edges after the wait, parking on the word at 0x20b
    apb(1'b0, `REG_PC_OFS, 32'h0);
    chk(rd, 32'h20b, "halted execute address");
    finish_test();
  end
endmodule
